// *** hw/asr_pkg.sv ***
// Constants, register map and carrier types for the serial receiver.
// Assumes a 16x baud sample tick from an outside baud generator and an
// AHB-Lite master that issues single word transfers.
// Operation
// - Frame is low start, 8 or 9 data bits LSB first, high stop.
// - Receive invert set flips the serial input before any sampling.
// - Completed character moves to an empty buffer and sets full flag.
// - Full buffer at completion sets overrun and drops character and errors.
// - Full flag clears by status-one read while set, then data read.
// - Input sampled at sixteen times baud, sixteen slots per bit.
// - Falling edge is a low sample after three high samples.
// - Start accepted when two of slots 3, 5, 7 are low.
// - Bits decided by majority of slots 8-10; start by slots 3, 5, 7.
// - Any sample in slots 8-10, or start slots 3, 5, 7, disagreeing with its bit sets noise on transfer.
// - Falling edges seen after the start bit realign the slot counter.
// - Framing error on non-break preloads edge history with three highs.
// - While framing flag set, completed characters are not transferred.
// - Sleep blocks all receiver flags except idle with idle-in-sleep.
// - Idle wake clears sleep after 10 or 11 idle bit times.
// - Waking idle sets idle flag only when idle-in-sleep is on.
// - Idle count starts after start bit, or after stop bit when selected.
// - Address wake clears sleep on high MSB; that character is received.
// - Three requests: transmit, receive, error; ten sources, own enables.
// - Transmit request from empty or done flag with its enable.
// - Idle clears by status then data read; rearms after new character.
// - Noise, framing, parity flags set with full flag, never on overrun.
// - Active edge while enabled sets edge flag; write one clears it.
// - Ninth received bit held in a separate control register bit.
package asr_pkg;

  // Register byte addresses.
  localparam logic [7:0] ADDR_CONTROL_REG_TWO = 8'h00;
  localparam logic [7:0] ADDR_STATUS_REG_ONE  = 8'h04;
  localparam logic [7:0] ADDR_STATUS_REG_TWO  = 8'h08;
  localparam logic [7:0] ADDR_DATA_REG        = 8'h0C;

  // Control register field positions.
  localparam int BIT_RX_ENABLE   = 0;
  localparam int BIT_RX_INVERT   = 1;
  localparam int BIT_NINE_BIT    = 2;
  localparam int BIT_WAKE_ADDR   = 3;
  localparam int BIT_IDLE_START  = 4;
  localparam int BIT_IDLE_SLEEP  = 5;
  localparam int BIT_RX_SLEEP    = 6;
  localparam int BIT_PARITY_EN   = 7;
  localparam int BIT_PARITY_ODD  = 8;
  localparam int BIT_IRQ_EN_LO   = 16;
  localparam int BIT_NINTH_RX    = 31;

  // Status register one positions.
  localparam int BIT_PARITY_ERR  = 0;
  localparam int BIT_FRAMING_ERR = 1;
  localparam int BIT_NOISE       = 2;
  localparam int BIT_OVERRUN     = 3;
  localparam int BIT_IDLE        = 4;
  localparam int BIT_RX_FULL     = 5;
  localparam int BIT_TX_DONE     = 6;
  localparam int BIT_TX_EMPTY    = 7;

  // Status register two positions, both write one to clear.
  localparam int BIT_RX_EDGE     = 0;
  localparam int BIT_BREAK       = 1;

  // Interrupt enable order inside the enable field.
  localparam int IE_TX_EMPTY = 0;
  localparam int IE_TX_DONE  = 1;
  localparam int IE_RX_FULL  = 2;
  localparam int IE_IDLE     = 3;
  localparam int IE_RX_EDGE  = 4;
  localparam int IE_BREAK    = 5;
  localparam int IE_OVERRUN  = 6;
  localparam int IE_NOISE    = 7;
  localparam int IE_FRAMING  = 8;
  localparam int IE_PARITY   = 9;
  localparam int IRQ_SOURCES = 10;

  // Sample slot timing.
  localparam logic [4:0] SLOT_FIRST  = 5'h01;
  localparam logic [4:0] SLOT_VOTE_A = 5'h03;
  localparam logic [4:0] SLOT_VOTE_B = 5'h05;
  localparam logic [4:0] SLOT_VOTE_C = 5'h07;
  localparam logic [4:0] SLOT_MAJ_A  = 5'h08;
  localparam logic [4:0] SLOT_MAJ_B  = 5'h09;
  localparam logic [4:0] SLOT_MAJ_C  = 5'h0A;
  localparam logic [4:0] SLOT_RESYNC = 5'h0B;
  localparam logic [4:0] SLOT_LAST   = 5'h10;

  // Frame geometry and idle length in bit times.
  localparam logic [3:0] STOP_IDX_8 = 4'h9;
  localparam logic [3:0] STOP_IDX_9 = 4'hA;
  localparam logic [7:0] IDLE_BITS_8 = 8'h0A;
  localparam logic [7:0] IDLE_BITS_9 = 8'h0B;
  localparam logic [7:0] SLOTS_PER_BIT = 8'h10;

  // Receiver configuration held in the control register.
  typedef struct packed {
    logic [IRQ_SOURCES-1:0] irqEn;
    logic                   parityOdd;
    logic                   parityEn;
    logic                   idleInSleep;
    logic                   idleCountStartSelect;
    logic                   wakeAddr;
    logic                   nineBit;
    logic                   rxInvert;
    logic                   rxEnableBit;
  } asr_cfg_type;

  localparam asr_cfg_type CFG_RESET = '0;

  // Receiver states, one-hot.
  typedef enum logic [1:0] {
    ST_HUNT  = 2'b01,
    ST_FRAME = 2'b10
  } asr_state_type;

endpackage

// *** hw/asr_receiver.sv ***
// Receive half of an asynchronous serial port with an AHB-Lite register
// slave. Assumes sampleTick pulses once per 16x baud period, rxIn is
// synchronous to mclk, and the transmitter reports its two status levels.
`timescale 1ns/10ps
module asr_receiver (
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        sampleTick,
  input  wire logic        rxIn,
  input  wire logic        txEmptyFlag,
  input  wire logic        txDoneFlag,
  output logic             irqTx,
  output logic             irqRx,
  output logic             irqErr
);
  import asr_pkg::*;

  asr_cfg_type   cfg;
  asr_state_type state;
  logic          rxSleep;
  logic [2:0]    hist;
  logic [4:0]    sampleSlot;
  logic [3:0]    bitIdx;
  logic [1:0]    zeros;
  logic [1:0]    votes;
  logic          noisy;
  logic [8:0]    shiftReg;
  logic [7:0]    idleCnt;
  logic          idleReady;
  logic [7:0]    dataReg;
  logic          ninthRxBit;
  logic          rxFullFlag;
  logic          idleFlag;
  logic          overrunFlag;
  logic          noiseFlag;
  logic          framingErrorFlag;
  logic          parityErrorFlag;
  logic          rxEdgeFlag;
  logic          breakDetectFlag;
  logic          armFull;
  logic          armIdle;
  logic          armErr;
  logic          wrPend;
  logic [7:0]    wrAddr;

  logic          rxs;
  logic          fallEdge;
  logic          tickFrame;
  logic          vote;
  logic          bitDone;
  logic          charDone;
  logic          sampleNoise;
  logic          startFail;
  logic          frameErr;
  logic          breakChar;
  logic          parityBad;
  logic          accept;
  logic          loadChar;
  logic          overrunHit;
  logic          msbHigh;
  logic          countEn;
  logic          idleHit;
  logic [3:0]    stopIdx;
  logic [3:0]    msbIdx;
  logic [7:0]    idleThr;
  logic          busTake;
  logic          rdStatus;
  logic          rdData;
  logic          clrSeq;
  logic          wrCtrl;
  logic          wrStat2;
  logic [31:0]   next_hrdata;
  logic [9:0]    irqSrc;

  assign rxs = rxIn ^ cfg.rxInvert;

  assign fallEdge = sampleTick && (hist == 3'b111) && !rxs;

  // Frame geometry follows the data length setting.
  assign stopIdx = cfg.nineBit ? STOP_IDX_9 : STOP_IDX_8;
  assign msbIdx  = stopIdx - 4'h1;
  assign idleThr = (cfg.nineBit ? IDLE_BITS_9 : IDLE_BITS_8) * SLOTS_PER_BIT;

  assign tickFrame = cfg.rxEnableBit && sampleTick && (state == ST_FRAME);
  assign vote = (votes[0] & votes[1]) | (votes[0] & rxs) | (votes[1] & rxs);
  assign bitDone = tickFrame && (sampleSlot == SLOT_MAJ_C) && (bitIdx != 4'h0);
  assign sampleNoise = bitDone && !((votes == 2'b11 && rxs) ||
                                    (votes == 2'b00 && !rxs));
  assign charDone = bitDone && (bitIdx == stopIdx);
  assign startFail = tickFrame && (bitIdx == 4'h0) &&
                     (sampleSlot == SLOT_VOTE_C) &&
                     ({1'b0, zeros} + {2'b00, !rxs} < 3'h2);

  // Character verdicts, valid only together with charDone, except msbHigh, which is valid alone at the MSB bit.
  assign frameErr  = charDone && !vote;
  assign breakChar = frameErr && (shiftReg == 9'h000);
  assign parityBad = cfg.parityEn && ((^shiftReg) ^ cfg.parityOdd);
  assign msbHigh   = bitDone && (bitIdx == msbIdx) && vote;

  assign accept = charDone && !rxSleep && !framingErrorFlag;
  assign loadChar = accept && !rxFullFlag;
  assign overrunHit = accept && rxFullFlag;

  assign countEn = cfg.rxEnableBit && ((state == ST_HUNT) ||
                   (!cfg.idleCountStartSelect && bitIdx != 4'h0));
  assign idleHit = sampleTick && countEn && rxs &&
                   (idleCnt == idleThr - 8'h01);

  // Bus decode; only the low byte of the address selects a register.
  assign busTake  = hsel && htrans[1] && hready;
  assign rdStatus = busTake && !hwrite && (haddr[7:0] == ADDR_STATUS_REG_ONE);
  assign rdData   = busTake && !hwrite && (haddr[7:0] == ADDR_DATA_REG);
  assign clrSeq   = rdData;
  assign wrCtrl   = wrPend && (wrAddr == ADDR_CONTROL_REG_TWO);
  assign wrStat2  = wrPend && (wrAddr == ADDR_STATUS_REG_TWO);

  // Receive sequencer: start search, slot counting and bit capture.
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      state      <= ST_HUNT;
      hist       <= 3'b000;
      sampleSlot <= SLOT_FIRST;
      bitIdx     <= 4'h0;
      zeros      <= 2'b00;
      votes      <= 2'b00;
      noisy      <= 1'b0;
      shiftReg   <= 9'h000;
    end else if (!cfg.rxEnableBit) begin
      state <= ST_HUNT;
      hist  <= 3'b000;
    end else if (sampleTick) begin
      hist       <= {hist[1:0], rxs};
      sampleSlot <= (sampleSlot == SLOT_LAST) ? SLOT_FIRST :
                    sampleSlot + 5'h01;
      unique case (state)
        ST_HUNT: begin
          if (fallEdge) begin
            state      <= ST_FRAME;
            sampleSlot <= SLOT_FIRST + 5'h01;
            bitIdx     <= 4'h0;
            zeros      <= 2'b00;
            noisy      <= 1'b0;
            shiftReg   <= 9'h000;
          end
        end
        ST_FRAME: begin
          if (bitIdx == 4'h0 && (sampleSlot == SLOT_VOTE_A ||
              sampleSlot == SLOT_VOTE_B || sampleSlot == SLOT_VOTE_C)) begin
            zeros <= zeros + {1'b0, !rxs};
            if (rxs) begin
              noisy <= 1'b1;
            end
          end
          if (bitIdx == 4'h0 && sampleSlot >= SLOT_MAJ_A &&
              sampleSlot <= SLOT_MAJ_C && rxs) begin
            noisy <= 1'b1;
          end
          if (sampleSlot == SLOT_MAJ_A) begin
            votes[0] <= rxs;
          end
          if (sampleSlot == SLOT_MAJ_B) begin
            votes[1] <= rxs;
          end
          if (sampleNoise) begin
            noisy <= 1'b1;
          end
          if (bitDone && bitIdx != stopIdx) begin
            shiftReg[bitIdx - 4'h1] <= vote;
          end
          if (sampleSlot == SLOT_LAST) begin
            bitIdx <= bitIdx + 4'h1;
          end
          if (fallEdge && bitIdx != 4'h0) begin
            sampleSlot <= SLOT_FIRST + 5'h01;
            if (sampleSlot >= SLOT_RESYNC) begin
              bitIdx <= bitIdx + 4'h1;
            end
          end
          if (startFail || charDone) begin
            state <= ST_HUNT;
          end
          if (frameErr && !breakChar) begin
            hist <= 3'b111;
          end else if (breakChar) begin
            hist <= 3'b000;
          end
        end
      endcase
    end
  end

  // Idle sample-tick counter, saturating so a long idle fires once.
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      idleCnt <= 8'h00;
    end else if (sampleTick) begin
      if (!countEn || !rxs) begin
        idleCnt <= 8'h00;
      end else if (idleCnt != idleThr) begin
        idleCnt <= idleCnt + 8'h01;
      end
    end
  end

  // Sleep bit: software may only set it, the wake logic clears it.
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      rxSleep <= 1'b0;
    end else begin
      if (idleHit && rxSleep && !cfg.wakeAddr) begin
        rxSleep <= 1'b0;
      end
      if (msbHigh && rxSleep && cfg.wakeAddr) begin
        rxSleep <= 1'b0;
      end
      if (wrCtrl && hwdata[BIT_RX_SLEEP]) begin
        rxSleep <= 1'b1;
      end
    end
  end

  // Receive buffer, ninth bit and buffer-full flag.
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      dataReg    <= 8'h00;
      ninthRxBit <= 1'b0;
      rxFullFlag <= 1'b0;
    end else begin
      if (clrSeq && armFull) begin
        rxFullFlag <= 1'b0;
      end
      if (loadChar) begin
        dataReg    <= shiftReg[7:0];
        ninthRxBit <= cfg.nineBit ? shiftReg[8] : 1'b0;
        rxFullFlag <= 1'b1;
      end
    end
  end

  // Error flags; a new set in the clearing cycle wins over the clear.
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      overrunFlag      <= 1'b0;
      noiseFlag        <= 1'b0;
      framingErrorFlag <= 1'b0;
      parityErrorFlag  <= 1'b0;
    end else begin
      if (clrSeq && armErr) begin
        overrunFlag      <= 1'b0;
        noiseFlag        <= 1'b0;
        framingErrorFlag <= 1'b0;
        parityErrorFlag  <= 1'b0;
      end
      if (overrunHit) begin
        overrunFlag <= 1'b1;
      end
      if (loadChar && (noisy || sampleNoise)) begin
        noiseFlag <= 1'b1;
      end
      if (loadChar && frameErr) begin
        framingErrorFlag <= 1'b1;
      end
      if (loadChar && parityBad) begin
        parityErrorFlag <= 1'b1;
      end
    end
  end

  // Idle flag with its rearm latch so a long idle line sets it once.
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      idleFlag  <= 1'b0;
      idleReady <= 1'b0;
    end else begin
      if (clrSeq && armIdle) begin
        idleFlag <= 1'b0;
      end
      if (loadChar) begin
        idleReady <= 1'b1;
      end
      if (idleHit && idleReady && (!rxSleep || cfg.idleInSleep)) begin
        idleFlag  <= 1'b1;
        idleReady <= 1'b0;
      end
    end
  end

  // Edge and break flags; both are write one to clear.
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      rxEdgeFlag      <= 1'b0;
      breakDetectFlag <= 1'b0;
    end else begin
      if (wrStat2 && hwdata[BIT_RX_EDGE]) begin
        rxEdgeFlag <= 1'b0;
      end
      if (wrStat2 && hwdata[BIT_BREAK]) begin
        breakDetectFlag <= 1'b0;
      end
      if (cfg.rxEnableBit && !rxSleep && sampleTick && hist[0] && !rxs) begin
        rxEdgeFlag <= 1'b1;
      end
      if (breakChar && !rxSleep) begin
        breakDetectFlag <= 1'b1;
      end
    end
  end

  // Clear-sequence arming: a status read notes which flags it saw set.
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      armFull <= 1'b0;
      armIdle <= 1'b0;
      armErr  <= 1'b0;
    end else if (rdStatus) begin
      armFull <= rxFullFlag;
      armIdle <= idleFlag;
      armErr  <= overrunFlag | noiseFlag | framingErrorFlag | parityErrorFlag;
    end else if (rdData) begin
      armFull <= 1'b0;
      armIdle <= 1'b0;
      armErr  <= 1'b0;
    end
  end

  // Write data phase capture; the slave never inserts wait states.
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      wrPend <= 1'b0;
      wrAddr <= 8'h00;
    end else begin
      wrPend <= busTake && hwrite;
      wrAddr <= haddr[7:0];
    end
  end

  // Control register fields other than sleep.
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      cfg <= CFG_RESET;
    end else if (wrCtrl) begin
      cfg.rxEnableBit          <= hwdata[BIT_RX_ENABLE];
      cfg.rxInvert             <= hwdata[BIT_RX_INVERT];
      cfg.nineBit              <= hwdata[BIT_NINE_BIT];
      cfg.wakeAddr             <= hwdata[BIT_WAKE_ADDR];
      cfg.idleCountStartSelect <= hwdata[BIT_IDLE_START];
      cfg.idleInSleep          <= hwdata[BIT_IDLE_SLEEP];
      cfg.parityEn             <= hwdata[BIT_PARITY_EN];
      cfg.parityOdd            <= hwdata[BIT_PARITY_ODD];
      cfg.irqEn <= hwdata[BIT_IRQ_EN_LO +: IRQ_SOURCES];
    end
  end

  // Read mux; unmapped addresses read as zero.
  always_comb begin
    next_hrdata = 32'h0000_0000;
    unique case (haddr[7:0])
      ADDR_CONTROL_REG_TWO: begin
        next_hrdata[BIT_RX_ENABLE]  = cfg.rxEnableBit;
        next_hrdata[BIT_RX_INVERT]  = cfg.rxInvert;
        next_hrdata[BIT_NINE_BIT]   = cfg.nineBit;
        next_hrdata[BIT_WAKE_ADDR]  = cfg.wakeAddr;
        next_hrdata[BIT_IDLE_START] = cfg.idleCountStartSelect;
        next_hrdata[BIT_IDLE_SLEEP] = cfg.idleInSleep;
        next_hrdata[BIT_RX_SLEEP]   = rxSleep;
        next_hrdata[BIT_PARITY_EN]  = cfg.parityEn;
        next_hrdata[BIT_PARITY_ODD] = cfg.parityOdd;
        next_hrdata[BIT_IRQ_EN_LO +: IRQ_SOURCES] = cfg.irqEn;
        next_hrdata[BIT_NINTH_RX]   = ninthRxBit;
      end
      ADDR_STATUS_REG_ONE: begin
        next_hrdata[BIT_PARITY_ERR]  = parityErrorFlag;
        next_hrdata[BIT_FRAMING_ERR] = framingErrorFlag;
        next_hrdata[BIT_NOISE]       = noiseFlag;
        next_hrdata[BIT_OVERRUN]     = overrunFlag;
        next_hrdata[BIT_IDLE]        = idleFlag;
        next_hrdata[BIT_RX_FULL]     = rxFullFlag;
        next_hrdata[BIT_TX_DONE]     = txDoneFlag;
        next_hrdata[BIT_TX_EMPTY]    = txEmptyFlag;
      end
      ADDR_STATUS_REG_TWO: begin
        next_hrdata[BIT_RX_EDGE] = rxEdgeFlag;
        next_hrdata[BIT_BREAK]   = breakDetectFlag;
      end
      ADDR_DATA_REG: begin
        next_hrdata[7:0] = dataReg;
      end
      default: begin
        next_hrdata = 32'h0000_0000;
      end
    endcase
  end

  // Read data registered at the address phase edge, OKAY always.
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hrdata    <= (busTake && !hwrite) ? next_hrdata : 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  assign irqSrc[IE_TX_EMPTY] = txEmptyFlag;
  assign irqSrc[IE_TX_DONE]  = txDoneFlag;
  assign irqSrc[IE_RX_FULL]  = rxFullFlag;
  assign irqSrc[IE_IDLE]     = idleFlag;
  assign irqSrc[IE_RX_EDGE]  = rxEdgeFlag;
  assign irqSrc[IE_BREAK]    = breakDetectFlag;
  assign irqSrc[IE_OVERRUN]  = overrunFlag;
  assign irqSrc[IE_NOISE]    = noiseFlag;
  assign irqSrc[IE_FRAMING]  = framingErrorFlag;
  assign irqSrc[IE_PARITY]   = parityErrorFlag;

  // Three request lines, registered so each output leaves a flip-flop.
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      irqTx  <= 1'b0;
      irqRx  <= 1'b0;
      irqErr <= 1'b0;
    end else begin
      irqTx  <= |(irqSrc[IE_TX_DONE:IE_TX_EMPTY] &
                  cfg.irqEn[IE_TX_DONE:IE_TX_EMPTY]);
      irqRx  <= |(irqSrc[IE_BREAK:IE_RX_FULL] &
                  cfg.irqEn[IE_BREAK:IE_RX_FULL]);
      irqErr <= |(irqSrc[IE_PARITY:IE_OVERRUN] &
                  cfg.irqEn[IE_PARITY:IE_OVERRUN]);
    end
  end

  // The transfer size is not checked; only whole-word access is expected.
  logic unusedSize;
  assign unusedSize = ^hsize;

endmodule

// *** tb/asr_receiver_assertions.sv ***
// Checker on the receiver ports: bus answers and interrupt causes.
// Assumes hready is the receiver's own hreadyout looped back.
`timescale 1ns/10ps
module asr_receiver_assertions
  import asr_pkg::*;
(
  input wire logic        mclk,
  input wire logic        resetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic        sampleTick,
  input wire logic        rxIn,
  input wire logic        txEmptyFlag,
  input wire logic        txDoneFlag,
  input wire logic        irqTx,
  input wire logic        irqRx,
  input wire logic        irqErr
);
  // Transfer decode as the slave sees it.
  logic taken;
  assign taken = hsel & htrans[1] & hready;

  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);

  // Flags set only on ticks or enable writes, and clear only by bus
  // access; the interrupt register adds one cycle to either path.
  sequence tickSet;
    $past(sampleTick, 2) || $past(taken, 3);
  endsequence
  sequence busClear;
    $past(taken, 1) || $past(taken, 2) || $past(taken, 3);
  endsequence

  ready_high_a: assert property (hreadyout == 1'b1)
    else $error("hreadyout went low");
  resp_okay_a: assert property (hresp == 1'b0)
    else $error("hresp not OKAY");
  rdata_idle_a: assert property (
    !$past(taken & ~hwrite) |-> hrdata == 32'h0) else $error("stray hrdata");
  tx_irq_low_a: assert property (
    $past(!txEmptyFlag && !txDoneFlag) |-> !irqTx) else $error("stray irqTx");
  tx_irq_rise_a: assert property (
    $rose(irqTx) |-> $past(txEmptyFlag || txDoneFlag)) else $error("irqTx");
  rx_irq_rise_a: assert property (
    $rose(irqRx) |-> tickSet) else $error("irqRx rose without cause");
  err_irq_rise_a: assert property (
    $rose(irqErr) |-> tickSet) else $error("irqErr rose without cause");
  rx_irq_fall_a: assert property (
    $fell(irqRx) |-> busClear) else $error("irqRx fell without access");
  err_irq_fall_a: assert property (
    $fell(irqErr) |-> busClear) else $error("irqErr fell without access");
endmodule

bind asr_receiver asr_receiver_assertions u_chk (.*);

// *** tb/asr_receiver_tb_top.sv ***
// Receiver bench: AHB-Lite master tasks and a serial peer on rxIn.
// Assumes zero wait states are possible but waits on hready anyway.
`timescale 1ns/10ps
module asr_receiver_tb_top;
  import asr_pkg::*;
  localparam logic [7:0] CT = ADDR_CONTROL_REG_TWO;
  localparam logic [7:0] ST = ADDR_STATUS_REG_ONE;
  localparam logic [7:0] DT = ADDR_DATA_REG;
  logic        mclk = 1'b0, resetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic        sampleTick = 1'b0, txEmptyFlag = 1'b1, txDoneFlag = 1'b0;
  logic        invLine = 1'b0, hready, hreadyout, hresp, rxLine, rxIn;
  logic        irqTx, irqRx, irqErr;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  int          err_count = 0, compares = 0;

  // Single slave, so its hreadyout is the bus hready.
  assign hready = hreadyout;
  assign rxIn = rxLine ^ invLine;
  always #12.5 mclk = ~mclk;
  // One tick every second cycle keeps frames short.
  always @(posedge mclk) sampleTick <= ~sampleTick;

  asr_receiver u_dut (.*);
  asr_serial_peer u_peer (.*);

  task automatic tally_and_finish();
    $display("compares %0d, mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wait_ready();
    for (int n = 0; n < 20; n++) begin
      @(posedge mclk);
      if (hready === 1'b1) return;
    end
    err_count++;
    tally_and_finish();
  endtask
  // One word transfer; a read compares its data-phase word with e.
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] e);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= e;
    wait_ready();
    if (!w) chk(hrdata, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(a, 1'b0, e);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask
  task automatic frame(input logic [8:0] d, input logic nine = 1'b0,
                       input logic stop = 1'b1, input int k = 999);
    u_peer.send(nine ? {stop, d, 1'b0} : {1'b1, stop, d[7:0], 1'b0},
                nine ? 11 : 10, k);
  endtask
  task automatic note(input string s);
    $display("test %s done, mismatches so far %0d", s, err_count);
  endtask

  // Tests run in order; the ninth-bit test is last as it leaves bit 31 set.
  initial begin
    repeat (20) @(posedge mclk);
    resetn <= 1'b1;
    repeat (2) @(posedge mclk);
    rd(CT, 32'h0);
    rd(8'h10, 32'h0);
    frame(9'h0A5);
    rd(ST, 32'h80);
    note("reset");
    wr(CT, 32'h1);
    frame(9'h0A5);
    rd(ST, 32'hA0);
    rd(DT, 32'hA5);
    rd(ST, 32'h80);
    rd(ADDR_STATUS_REG_TWO, 32'h1);
    wr(ADDR_STATUS_REG_TWO, 32'h1);
    rd(ADDR_STATUS_REG_TWO, 32'h0);
    repeat (400) @(posedge mclk);
    rd(ST, 32'h90);
    rd(DT, 32'hA5);
    rd(ST, 32'h80);
    repeat (400) @(posedge mclk);
    rd(ST, 32'h80);
    note("basic and idle");
    wr(CT, 32'h0044_0001);
    frame(9'h011);
    chk({31'h0, irqRx}, 32'h1);
    frame(9'h022);
    chk({31'h0, irqErr}, 32'h1);
    rd(ST, 32'hA8);
    rd(DT, 32'h11);
    repeat (3) @(posedge mclk);
    chk({30'h0, irqRx, irqErr}, 32'h0);
    // The glitch lifts slot 9 of a low data bit, so no false edge follows.
    frame(9'h03C, 1'b0, 1'b1, 24);
    rd(ST, 32'hA4);
    rd(DT, 32'h3C);
    note("overrun and noise");
    // A break keeps the edge history clear, so its low stop tail cannot
    // start a false frame that would swallow the next character.
    frame(9'h000, 1'b0, 1'b0);
    rd(ST, 32'hA2);
    frame(9'h042);
    rd(ST, 32'hA2);
    rd(DT, 32'h00);
    wr(CT, 32'h3);
    invLine <= 1'b1;
    frame(9'h05A);
    rd(ST, 32'hA0);
    rd(DT, 32'h5A);
    wr(CT, 32'h49);
    invLine <= 1'b0;
    frame(9'h012);
    rd(ST, 32'h80);
    rd(CT, 32'h49);
    frame(9'h092);
    rd(CT, 32'h09);
    rd(ST, 32'hA0);
    rd(DT, 32'h92);
    wr(CT, 32'h41);
    repeat (400) @(posedge mclk);
    rd(CT, 32'h01);
    rd(ST, 32'h80);
    note("framing, invert, wake");
    wr(CT, 32'h0002_0001);
    repeat (3) @(posedge mclk);
    chk({31'h0, irqTx}, 32'h0);
    txDoneFlag <= 1'b1;
    repeat (3) @(posedge mclk);
    chk({31'h0, irqTx}, 32'h1);
    wr(CT, 32'h5);
    frame(9'h1C3, 1'b1);
    rd(CT, 32'h8000_0005);
    rd(ST, 32'hE0);
    rd(DT, 32'hC3);
    note("transmit irq and nine bit");
    tally_and_finish();
  end
endmodule

// *** tb/asr_serial_peer.sv ***
// Remote serial sender that drives the receive line, 16 ticks a bit.
// Assumes sampleTick is the receiver's oversampling tick.
`timescale 1ns/10ps
module asr_serial_peer (
  input  wire logic mclk,
  input  wire logic sampleTick,
  output logic      rxLine
);
  // The line rests at mark level between frames.
  initial rxLine = 1'b1;

  // Next edge that carries a tick; bounded since ticks never stop.
  task automatic tick_wait();
    for (int j = 0; j < 4; j++) begin
      @(posedge mclk);
      if (sampleTick === 1'b1) break;
    end
  endtask

  // sixteen slots a bit
  // Slot k, when inside the frame, is flipped once to fake line noise.
  task automatic send(input logic [10:0] bits, input int n, input int k);
    // Idle ticks first: a receiver enabled just before needs three highs
    // in its edge history, or the start bit would go unseen.
    rxLine <= 1'b1;
    repeat (4) tick_wait();
    for (int i = 0; i < n * 16; i++) begin
      rxLine <= bits[i / 16] ^ (i == k);
      tick_wait();
    end
    rxLine <= 1'b1;
    tick_wait();
  endtask
endmodule
